// [hdl/dpaf_pkg.sv]
// Purpose: constants shared by the dual-port flag/port host controller
// Assumes: 25 MHz system clock, 8K-deep variant with 18 data bits
// Notes:   register indices are word offsets on the avalon slave
package dpaf_pkg;

  // pin widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 18;

  // avalon register word offsets
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_WDATA  = 3'h2;
  localparam logic [2:0] REG_CMD    = 3'h3;
  localparam logic [2:0] REG_RDATA  = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;

  // field positions
  localparam int CTRL_DRIVE_BIT  = 0;
  localparam int CTRL_BLOCK_BIT  = 1;
  localparam int CMD_GO_BIT      = 0;
  localparam int CMD_OP_LSB      = 1;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_IRQ_BIT      = 1;
  localparam int ST_CONFLICT_BIT = 2;
  localparam int ST_OWNED_BIT    = 3;
  localparam int ST_FLAGPIN_BIT  = 4;

  // semaphore index sits in the low address bits
  localparam int SEM_IDX_W = 3;

  // reset values
  localparam logic [1:0]        CTRL_RST  = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 18'h00000;

  // timing, in ns as printed, then cycles derived from the clock
  localparam int CLK_NS      = 40;
  localparam int T_BUSY_NS   = 20;
  localparam int T_ACC_NS    = 25;
  localparam int T_WP_NS     = 20;
  localparam int SYNC_STAGES = 2;
  localparam int BUSY_CYC    = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETUP_CNT =
    4'(BUSY_CYC + ACC_CYC + SYNC_STAGES);
  localparam logic [3:0] PULSE_CNT = 4'(WP_CYC);

  typedef enum logic [1:0] {
    OP_MEM_RD = 2'b00,
    OP_MEM_WR = 2'b01,
    OP_SEM_RD = 2'b10,
    OP_SEM_WR = 2'b11
  } dpaf_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_CHECK = 3'b010,
    ST_PULSE = 3'b011,
    ST_RECOV = 3'b100,
    ST_END   = 3'b101
  } dpaf_state_t;

endpackage

// [hdl/dpaf_sync.sv]
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: bits are independent levels
// Notes:   multi-bit words are only read after they have been stable
`timescale 1ns/1ps
`default_nettype none
module dpaf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          meta_r[i] <= 1'b1;
          q_out[i]  <= 1'b1;
        end else begin
          meta_r[i] <= d_in[i];
          q_out[i]  <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [hdl/dpaf_host.sv]
// Purpose: host controller driving one port of a two-port static memory
// Assumes: software reaches it over avalon-mm with waitrequest
// Notes:   memory data, semaphores, mailbox and conflict pin on one port
//
// Summary of operation
// - host keeps memory enable high and flag select low for semaphores.
// - host holds address and enable until conflict flag settles, then writes.
// - host stalls a memory access while its conflict flag is low, except in slave mode where it drives the pin itself; semaphore accesses go ahead.
// - in slave mode host holds conflict inputs high, or low to block writes.
// - software writes one to every semaphore after power-up.
`timescale 1ns/1ps
`default_nettype none
module dpaf_host
  import dpaf_pkg::*;
(
  // clock and reset
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_B_IN,
  // avalon-mm slave
  input  wire logic [2:0]        AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire logic [31:0]       AVS_WRITEDATA_IN,
  output var  logic [31:0]       AVS_READDATA_OUT,
  output var  logic              AVS_WAITREQUEST_OUT,
  // memory port control, active low
  output var  logic              PORT_CE_B_OUT,
  output var  logic              PORT_OE_B_OUT,
  output var  logic              PORT_RW_B_OUT,
  output var  logic              PORT_FLAG_SPACE_SELECT_B_OUT,
  output var  logic [ADDR_W-1:0] PORT_ADDR_OUT,
  // data pins, two-way
  input  wire logic [DATA_W-1:0] PORT_DQ_IN,
  output var  logic [DATA_W-1:0] PORT_DQ_OUT,
  output var  logic              PORT_DQ_OE_OUT,
  // conflict flag pin, two-way, active low
  input  wire logic              CONFLICT_FLAG_B_IN,
  output var  logic              CONFLICT_FLAG_B_OUT,
  output var  logic              CONFLICT_FLAG_OE_OUT,
  // mailbox interrupt pin, active low
  input  wire logic              MAILBOX_IRQ_B_IN
);

  // synchronised pins
  logic [DATA_W+1:0] pin_sync;
  logic [DATA_W-1:0] dq_s;
  logic              conflict_b_s;
  logic              irq_b_s;

  dpaf_sync #(.W(DATA_W + 2)) u_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     ({MAILBOX_IRQ_B_IN, CONFLICT_FLAG_B_IN, PORT_DQ_IN}),
    .q_out    (pin_sync)
  );

  assign dq_s         = pin_sync[DATA_W-1:0];
  assign conflict_b_s = pin_sync[DATA_W];
  assign irq_b_s      = pin_sync[DATA_W+1];

  // ---------------- bus group ----------------
  logic [1:0]        ctrl_r,  ctrl_nxt;
  logic [ADDR_W-1:0] addr_r,  addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic              wait_r,  wait_nxt;
  logic [31:0]       rdbus_r, rdbus_nxt;
  logic              bus_take;
  logic              start;
  dpaf_op_t          start_op;
  logic              conflict_clr;

  // engine state read by the bus
  dpaf_state_t       state_r, state_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              seen_r,  seen_nxt;
  logic              owned_r, owned_nxt;

  always_comb begin
    ctrl_nxt     = ctrl_r;
    addr_nxt     = addr_r;
    wdata_nxt    = wdata_r;
    rdbus_nxt    = rdbus_r;
    wait_nxt     = 1'b1;
    start        = 1'b0;
    start_op     = dpaf_op_t'(AVS_WRITEDATA_IN[CMD_OP_LSB +: 2]);
    conflict_clr = 1'b0;
    // a command write waits in waitrequest while the engine is busy
    bus_take = (AVS_READ_IN || AVS_WRITE_IN) && wait_r &&
               !(AVS_WRITE_IN && AVS_ADDRESS_IN == REG_CMD &&
                 state_r != ST_IDLE);
    if (bus_take) begin
      wait_nxt  = 1'b0;
      rdbus_nxt = 32'h0;
      if (AVS_READ_IN) begin
        case (AVS_ADDRESS_IN)
          REG_CTRL:   rdbus_nxt[1:0] = ctrl_r;
          REG_ADDR:   rdbus_nxt[ADDR_W-1:0] = addr_r;
          REG_WDATA:  rdbus_nxt[DATA_W-1:0] = wdata_r;
          REG_RDATA:  rdbus_nxt[DATA_W-1:0] = rdata_r;
          REG_STATUS: begin
            rdbus_nxt[ST_BUSY_BIT]     = (state_r != ST_IDLE);
            rdbus_nxt[ST_IRQ_BIT]      = !irq_b_s;
            rdbus_nxt[ST_CONFLICT_BIT] = seen_r;
            rdbus_nxt[ST_OWNED_BIT]    = owned_r;
            rdbus_nxt[ST_FLAGPIN_BIT]  = !conflict_b_s;
          end
          default:    rdbus_nxt = 32'h0;
        endcase
      end
    end
    // writes take effect at the edge where waitrequest is seen low
    if (AVS_WRITE_IN && !wait_r) begin
      case (AVS_ADDRESS_IN)
        REG_CTRL:   ctrl_nxt  = AVS_WRITEDATA_IN[1:0];
        REG_ADDR:   addr_nxt  = AVS_WRITEDATA_IN[ADDR_W-1:0];
        REG_WDATA:  wdata_nxt = AVS_WRITEDATA_IN[DATA_W-1:0];
        REG_CMD:    start     = AVS_WRITEDATA_IN[CMD_GO_BIT];
        REG_STATUS: conflict_clr = AVS_WRITEDATA_IN[ST_CONFLICT_BIT];
        default:    ctrl_nxt  = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl_r  <= CTRL_RST;
      addr_r  <= ADDR_RST;
      wdata_r <= DATA_RST;
      wait_r  <= 1'b1;
      rdbus_r <= 32'h0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      wait_r  <= wait_nxt;
      rdbus_r <= rdbus_nxt;
    end
  end

  assign AVS_WAITREQUEST_OUT = wait_r;
  assign AVS_READDATA_OUT    = rdbus_r;

  // conflict pin drive for a device strapped as slave
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      CONFLICT_FLAG_OE_OUT <= 1'b0;
      CONFLICT_FLAG_B_OUT  <= 1'b1;
    end else begin
      CONFLICT_FLAG_OE_OUT <= ctrl_nxt[CTRL_DRIVE_BIT];
      CONFLICT_FLAG_B_OUT  <= !ctrl_nxt[CTRL_BLOCK_BIT];
    end
  end

  // ---------------- engine group ----------------
  dpaf_op_t          op_r,   op_nxt;
  logic [3:0]        cnt_r,  cnt_nxt;
  logic              ce_b_r, ce_b_nxt;
  logic              oe_b_r, oe_b_nxt;
  logic              rw_b_r, rw_b_nxt;
  logic              fs_b_r, fs_b_nxt;
  logic [ADDR_W-1:0] pa_r,   pa_nxt;
  logic [DATA_W-1:0] dq_r,   dq_nxt;
  logic              dqoe_r, dqoe_nxt;
  logic              is_sem;
  logic              is_wr;
  logic              stall;

  assign is_sem = op_r[1];
  assign is_wr  = op_r[0];
  // when we drive the pin ourselves the device is a slave and never stalls
  assign stall  = !conflict_b_s && !ctrl_r[CTRL_DRIVE_BIT];

  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    cnt_nxt   = cnt_r;
    ce_b_nxt  = ce_b_r;
    oe_b_nxt  = oe_b_r;
    rw_b_nxt  = rw_b_r;
    fs_b_nxt  = fs_b_r;
    pa_nxt    = pa_r;
    dq_nxt    = dq_r;
    dqoe_nxt  = dqoe_r;
    rdata_nxt = rdata_r;
    owned_nxt = owned_r;
    seen_nxt  = seen_r;
    if (conflict_clr) begin
      seen_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          op_nxt    = start_op;
          state_nxt = ST_SETUP;
          cnt_nxt   = SETUP_CNT;
          pa_nxt    = addr_r;
          // semaphores: memory enable high, flag select low
          ce_b_nxt  = start_op[1];
          fs_b_nxt  = !start_op[1];
          oe_b_nxt  = start_op[0];
          dqoe_nxt  = start_op[0];
          dq_nxt    = start_op[1] ?
                      {{(DATA_W-1){1'b0}}, wdata_r[0]} : wdata_r;
        end
      end
      ST_SETUP: begin
        // address and enable held while the master flag settles
        if (cnt_r <= 4'h1) begin
          state_nxt = ST_CHECK;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_CHECK: begin
        if (stall && !is_sem) begin
          seen_nxt = 1'b1;
        end else if (is_wr) begin
          state_nxt = ST_PULSE;
          cnt_nxt   = PULSE_CNT;
          rw_b_nxt  = 1'b0;
        end else begin
          // the device latches the flag while select and oe stay low
          rdata_nxt = dq_s;
          if (is_sem) begin
            owned_nxt = !dq_s[0];
          end
          state_nxt = ST_END;
        end
      end
      ST_PULSE: begin
        if (cnt_r <= 4'h1) begin
          rw_b_nxt  = 1'b1;
          state_nxt = ST_RECOV;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_RECOV: begin
        state_nxt = ST_END;
      end
      ST_END: begin
        // both selects high: the port drops to standby
        ce_b_nxt  = 1'b1;
        fs_b_nxt  = 1'b1;
        oe_b_nxt  = 1'b1;
        dqoe_nxt  = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        ce_b_nxt  = 1'b1;
        fs_b_nxt  = 1'b1;
        oe_b_nxt  = 1'b1;
        rw_b_nxt  = 1'b1;
        dqoe_nxt  = 1'b0;
      end
    endcase
    if (stall && (state_r == ST_CHECK || state_r == ST_PULSE)) begin
      seen_nxt = 1'b1; // set wins over a clear in the same cycle
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_r <= ST_IDLE;
      op_r    <= OP_MEM_RD;
      cnt_r   <= 4'h0;
      ce_b_r  <= 1'b1;
      oe_b_r  <= 1'b1;
      rw_b_r  <= 1'b1;
      fs_b_r  <= 1'b1;
      pa_r    <= ADDR_RST;
      dq_r    <= DATA_RST;
      dqoe_r  <= 1'b0;
      rdata_r <= DATA_RST;
      owned_r <= 1'b0;
      seen_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      ce_b_r  <= ce_b_nxt;
      oe_b_r  <= oe_b_nxt;
      rw_b_r  <= rw_b_nxt;
      fs_b_r  <= fs_b_nxt;
      pa_r    <= pa_nxt;
      dq_r    <= dq_nxt;
      dqoe_r  <= dqoe_nxt;
      rdata_r <= rdata_nxt;
      owned_r <= owned_nxt;
      seen_r  <= seen_nxt;
    end
  end

  assign PORT_CE_B_OUT                = ce_b_r;
  assign PORT_OE_B_OUT                = oe_b_r;
  assign PORT_RW_B_OUT                = rw_b_r;
  assign PORT_FLAG_SPACE_SELECT_B_OUT = fs_b_r;
  assign PORT_ADDR_OUT                = pa_r;
  assign PORT_DQ_OUT                  = dq_r;
  assign PORT_DQ_OE_OUT               = dqoe_r;

endmodule
`default_nettype wire

// [testbench/dpaf_asserts.sv]
// Purpose: port checks for the flag/port host controller
// Assumes: one clock, async active-low reset
// Notes:   the stall check allows for the two-flop pin sync
`timescale 1ns/1ps
`default_nettype none
module dpaf_chk
  import dpaf_pkg::*;
(
  // clock and reset
  input wire logic              SYS_CLK_IN,
  input wire logic              RST_B_IN,
  // watched ports
  input wire logic              AVS_WAITREQUEST_OUT,
  input wire logic              PORT_CE_B_OUT,
  input wire logic              PORT_OE_B_OUT,
  input wire logic              PORT_RW_B_OUT,
  input wire logic              PORT_FLAG_SPACE_SELECT_B_OUT,
  input wire logic [ADDR_W-1:0] PORT_ADDR_OUT,
  input wire logic [DATA_W-1:0] PORT_DQ_OUT,
  input wire logic              PORT_DQ_OE_OUT,
  input wire logic              CONFLICT_FLAG_B_IN,
  input wire logic              CONFLICT_FLAG_OE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence s_pulse;
    !PORT_RW_B_OUT ##1 PORT_RW_B_OUT;
  endsequence
  sequence s_idle;
    PORT_CE_B_OUT && PORT_FLAG_SPACE_SELECT_B_OUT;
  endsequence
  property p_ans;
    $fell(AVS_WAITREQUEST_OUT) |=> AVS_WAITREQUEST_OUT;
  endproperty
  property p_sem_sel;
    !PORT_FLAG_SPACE_SELECT_B_OUT |-> PORT_CE_B_OUT;
  endproperty
  property p_bit0;
    !PORT_FLAG_SPACE_SELECT_B_OUT && PORT_DQ_OE_OUT |->
      PORT_DQ_OUT[DATA_W-1:1] == '0;
  endproperty
  property p_setup;
    $fell(PORT_RW_B_OUT) |-> PORT_ADDR_OUT == $past(PORT_ADDR_OUT, 4) &&
      !$past(PORT_CE_B_OUT && PORT_FLAG_SPACE_SELECT_B_OUT, 4);
  endproperty
  property p_pulse;
    $fell(PORT_RW_B_OUT) |-> s_pulse;
  endproperty
  // a pin held low must have been seen high again before the pulse
  property p_stall;
    $fell(PORT_RW_B_OUT) && !PORT_CE_B_OUT && !CONFLICT_FLAG_OE_OUT |->
      $past(CONFLICT_FLAG_B_IN, 2) || $past(CONFLICT_FLAG_B_IN, 3);
  endproperty
  property p_wr_dir;
    !PORT_RW_B_OUT |-> PORT_DQ_OE_OUT && PORT_OE_B_OUT;
  endproperty
  property p_gap;
    $rose(PORT_CE_B_OUT && PORT_FLAG_SPACE_SELECT_B_OUT) |=> s_idle;
  endproperty
  a_ans: assert property (p_ans) else $error("long answer");
  a_sem_sel: assert property (p_sem_sel) else $error("sel");
  a_bit0: assert property (p_bit0) else $error("flag data");
  a_setup: assert property (p_setup) else $error("setup");
  a_pulse: assert property (p_pulse) else $error("pulse");
  a_stall: assert property (p_stall) else $error("no stall");
  a_wr_dir: assert property (p_wr_dir) else $error("write dir");
  a_gap: assert property (p_gap) else $error("no gap");
endmodule
bind dpaf_host dpaf_chk dpaf_chk_inst (
  .SYS_CLK_IN, .RST_B_IN, .AVS_WAITREQUEST_OUT, .PORT_CE_B_OUT,
  .PORT_OE_B_OUT, .PORT_RW_B_OUT, .PORT_FLAG_SPACE_SELECT_B_OUT,
  .PORT_ADDR_OUT, .PORT_DQ_OUT, .PORT_DQ_OE_OUT, .CONFLICT_FLAG_B_IN,
  .CONFLICT_FLAG_OE_OUT);
`default_nettype wire

// [testbench/dpaf_dev.sv]
// Purpose: behavioural two-port memory seen from the left port
// Assumes: 8K deep, 18 bits; right port acts through tasks
// Notes:   flags are unknown until both sides write one
`timescale 1ns/1ps
`default_nettype none
module dpaf_dev
  import dpaf_pkg::*;
(
  // left port pins
  input  wire logic              ce_b_in,
  input  wire logic              oe_b_in,
  input  wire logic              rw_b_in,
  input  wire logic              sel_b_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              conf_b_in,
  // driven back
  output var  logic [DATA_W-1:0] dq_out,
  output var  logic              conf_b_out,
  output var  logic              irq_b_out
);
  logic [DATA_W-1:0] mem [0:8191];
  logic [7:0]        own [2];
  logic [7:0]        req [2];
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] held = '0;
  logic              sem_q;
  logic              irq_r_b = 1'b1;
  wire               mem_rd = rw_b_in & ~oe_b_in & ~ce_b_in & sel_b_in;
  wire               sem_rd = rw_b_in & ~oe_b_in & ~sel_b_in;
  initial begin
    conf_b_out = 1'b1;
    irq_b_out = 1'b1;
  end
  // only this side's flag is modelled: the right port settled first
  task automatic set_busy(input logic b);
    conf_b_out <= b;
  endtask
  task automatic sem_wr(input int s, input logic [2:0] i, input logic b);
    req[s][i] = !b;
    if (b) begin
      if (own[s][i] === 1'b1) own[1-s][i] = req[1-s][i];
      own[s][i] = 1'b0;
    end else if (own[1-s][i] !== 1'b1) own[s][i] = 1'b1;
  endtask
  // mailbox cells are fixed at the top two words of the 8K array, 1ffe and 1fff
  task automatic right_wr(input logic [12:0] a, input logic [17:0] d);
    mem[a] = d;
    if (a == 13'h1ffe) irq_b_out <= 1'b0;
  endtask
  task automatic right_rd(input logic [12:0] a);
    if (a == 13'h1fff) irq_r_b = 1'b1;
  endtask
  // a write lands on its rising edge; a low conflict pin blocks a memory write, not a flag write
  always @(posedge rw_b_in) begin
    if (!sel_b_in && ce_b_in) sem_wr(0, addr_in[2:0], dq_in[0]);
    else if (!ce_b_in && conf_b_in) begin
      mem[addr_in] = dq_in;
      if (addr_in == 13'h1fff) irq_r_b = 1'b0;
    end
  end
  always @(negedge (sel_b_in | oe_b_in)) begin
    #1 sem_q = !own[0][addr_in[2:0]];
  end
  always @* if (!ce_b_in && !oe_b_in && addr_in == 13'h1ffe) begin
    irq_b_out <= 1'b1;
  end
  // continuous, so a cell written while its address stands is seen at once
  assign val = sem_rd ? {DATA_W{sem_q}} : mem[addr_in];
  always @* if (mem_rd | sem_rd) held = val;
  assign dq_out = (mem_rd | sem_rd) ? val : ~held;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Purpose: self-checking bench for the flag/port host controller
// Assumes: 25 MHz clock, device modelled on the far side
// Notes:   right port activity comes through model tasks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dpaf_pkg::*;
  logic              clk, rst_b, rd, wr, wreq, dq_oe, cf_o, cf_oe, irq_b;
  logic              ce_b, oe_b, rw_b, sel_b, dev_cf;
  logic [2:0]        adr;
  logic [31:0]       wdat, rdat, q;
  logic [12:0]       paddr;
  logic [17:0]       dq_o, dq_d;
  logic [3:0]        steps [10] = '{1, 9, 6, 2, 13, 7, 10, 15, 1, 7};
  int                failures = 0;
  int                comparisons = 0;
  wire               cf_pin = cf_oe ? cf_o : dev_cf;
  wire [17:0]        dq_pin = dq_oe ? dq_o : dq_d;
  dpaf_host dpaf_host_inst (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
    .PORT_CE_B_OUT(ce_b), .PORT_OE_B_OUT(oe_b), .PORT_RW_B_OUT(rw_b),
    .PORT_FLAG_SPACE_SELECT_B_OUT(sel_b), .PORT_ADDR_OUT(paddr),
    .PORT_DQ_IN(dq_pin), .PORT_DQ_OUT(dq_o), .PORT_DQ_OE_OUT(dq_oe),
    .CONFLICT_FLAG_B_IN(cf_pin), .CONFLICT_FLAG_B_OUT(cf_o),
    .CONFLICT_FLAG_OE_OUT(cf_oe), .MAILBOX_IRQ_B_IN(irq_b));
  dpaf_dev dpaf_dev_inst (
    .ce_b_in(ce_b), .oe_b_in(oe_b), .rw_b_in(rw_b), .sel_b_in(sel_b),
    .addr_in(paddr), .dq_in(dq_pin), .conf_b_in(cf_pin), .dq_out(dq_d),
    .conf_b_out(dev_cf), .irq_b_out(irq_b));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic r, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= r;
    wr <= !r;
    adr <= a;
    wdat <= d;
    // only the watchdog ends a wait for the answer
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [31:0] exp);
    av(1'b1, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic idle();
    do av(1'b1, REG_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic run(input dpaf_op_t op);
    av(1'b0, REG_CMD, 32'({op, 1'b1}));
    idle();
  endtask
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 3'h0;
    wdat = 32'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdc(REG_CTRL, 32'h0);
    rdc(REG_ADDR, 32'h0);
    rdc(3'h6, 32'h0);
    av(1'b0, REG_WDATA, 32'h1);
    for (int i = 0; i < 8; i++) begin
      dpaf_dev_inst.sem_wr(1, 3'(i), 1'b1);
      av(1'b0, REG_ADDR, 32'(i));
      run(OP_SEM_WR);
    end
    // upper address bits must not matter in flag space
    av(1'b0, REG_ADDR, 32'h1ffd);
    run(OP_SEM_RD);
    rdc(REG_RDATA, 32'h3ffff);
    foreach (steps[k]) begin
      if (steps[k][3]) dpaf_dev_inst.sem_wr(1, 3'h5, steps[k][2]);
      else begin
        av(1'b0, REG_WDATA, 32'h3fffe | 32'(steps[k][2]));
        run(OP_SEM_WR);
      end
      run(OP_SEM_RD);
      chk(q[ST_OWNED_BIT], !steps[k][1]);
      rdc(REG_RDATA, {14'h0, {18{steps[k][1]}}});
      chk(dpaf_dev_inst.own[1][5], !steps[k][0]);
    end
    av(1'b0, REG_ADDR, 32'h1fff);
    av(1'b0, REG_WDATA, 32'h2a5a5);
    run(OP_MEM_WR);
    chk(dpaf_dev_inst.irq_r_b, 1'b0);
    dpaf_dev_inst.right_rd(13'h1fff);
    dpaf_dev_inst.right_wr(13'h1ffe, 18'h0c3c3);
    run(OP_MEM_RD);
    rdc(REG_RDATA, 32'h2a5a5);
    rdc(REG_STATUS, 32'h2);
    av(1'b0, REG_ADDR, 32'h1ffe);
    run(OP_MEM_RD);
    rdc(REG_RDATA, 32'h0c3c3);
    rdc(REG_STATUS, 32'h0);
    dpaf_dev_inst.set_busy(1'b0);
    av(1'b0, REG_ADDR, 32'h0100);
    av(1'b0, REG_WDATA, 32'h11111);
    av(1'b0, REG_CMD, 32'({OP_MEM_WR, 1'b1}));
    repeat (20) @(posedge clk);
    rdc(REG_STATUS, 32'h15);
    dpaf_dev_inst.set_busy(1'b1);
    idle();
    av(1'b0, REG_STATUS, 32'h4);
    rdc(REG_STATUS, 32'h0);
    run(OP_MEM_RD);
    rdc(REG_RDATA, 32'h11111);
    av(1'b0, REG_CTRL, 32'h3);
    repeat (4) @(posedge clk);
    rdc(REG_STATUS, 32'h10);
    chk(cf_pin, 1'b0);
    av(1'b0, REG_WDATA, 32'h22222);
    run(OP_MEM_WR);
    av(1'b0, REG_CTRL, 32'h1);
    run(OP_MEM_RD);
    rdc(REG_RDATA, 32'h11111);
    close_out();
  end
endmodule
`default_nettype wire
